// >>> include/bram_pkg.sv
// Shared constants, types and shape helpers for the configurable block RAM
package bram_pkg;

  localparam int ADDR_W = 14;
  localparam int DATA_W = 40;
  localparam int BE_W   = 4;
  localparam int ROWS   = 512;
  localparam int ROW_W  = 9;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] SHAPE_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // Field positions
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_CLK_LSB    = 2;
  localparam int CTRL_SMALL_BIT  = 4;
  localparam int CTRL_RDW_BIT    = 5;
  localparam int SHAPE_A_LSB     = 0;
  localparam int SHAPE_B_LSB     = 8;
  localparam int STATUS_OK_BIT   = 0;
  localparam int STATUS_CLRA_BIT = 1;
  localparam int STATUS_CLRB_BIT = 2;
  localparam int STATUS_COL_BIT  = 3;

  typedef enum logic [1:0] {
    MODE_SP  = 2'h0,
    MODE_SDP = 2'h1,
    MODE_TDP = 2'h2,
    MODE_ROM = 2'h3
  } mem_mode_type;

  typedef enum logic [1:0] {
    CLK_SINGLE = 2'h0,
    CLK_RW     = 2'h1,
    CLK_IO     = 2'h2,
    CLK_INDEP  = 2'h3
  } clk_mode_type;

  // Width codes
  localparam logic [3:0] W1  = 4'h0;
  localparam logic [3:0] W2  = 4'h1;
  localparam logic [3:0] W4  = 4'h2;
  localparam logic [3:0] W5  = 4'h3;
  localparam logic [3:0] W8  = 4'h4;
  localparam logic [3:0] W10 = 4'h5;
  localparam logic [3:0] W16 = 4'h6;
  localparam logic [3:0] W20 = 4'h7;
  localparam logic [3:0] W32 = 4'h8;
  localparam logic [3:0] W40 = 4'h9;

  localparam logic [5:0]  TDP_MAX_W   = 6'h14;
  localparam logic [13:0] SMALL_MASK_WIDE   = 14'h001f;
  localparam logic [13:0] SMALL_MASK_NARROW = 14'h003f;

  // Reset values
  localparam logic [1:0] MODE_RST  = 2'h0;
  localparam logic [1:0] CLK_RST   = 2'h0;
  localparam logic [3:0] SHAPE_RST = 4'h9;

  function automatic logic [5:0] width_of(input logic [3:0] c);
    case (c)
      W1:      width_of = 6'h01;
      W2:      width_of = 6'h02;
      W4:      width_of = 6'h04;
      W5:      width_of = 6'h05;
      W8:      width_of = 6'h08;
      W10:     width_of = 6'h0a;
      W16:     width_of = 6'h10;
      W20:     width_of = 6'h14;
      W32:     width_of = 6'h20;
      W40:     width_of = 6'h28;
      default: width_of = 6'h01;
    endcase
  endfunction : width_of

  // Log2 of the number of words held in one 40-bit row
  function automatic logic [2:0] lg_items(input logic [3:0] c);
    case (c)
      W1:          lg_items = 3'h5;
      W2:          lg_items = 3'h4;
      W4, W5:      lg_items = 3'h3;
      W8, W10:     lg_items = 3'h2;
      W16, W20:    lg_items = 3'h1;
      default:     lg_items = 3'h0;
    endcase
  endfunction : lg_items

  function automatic logic is_par(input logic [3:0] c);
    is_par = (c == W5) || (c == W10) || (c == W20) || (c == W40);
  endfunction : is_par

  function automatic logic small_ok(input logic [3:0] c);
    small_ok = (c == W8) || (c == W10) || (c == W16) || (c == W20);
  endfunction : small_ok

  function automatic logic [13:0] small_mask(input logic [3:0] c);
    small_mask = ((c == W16) || (c == W20)) ? SMALL_MASK_WIDE
                                            : SMALL_MASK_NARROW;
  endfunction : small_mask

  // Byte-enable lane of a logical data bit
  function automatic logic [1:0] lane_of(input logic [5:0] k,
                                         input logic       par);
    if (!par)
      lane_of = k[4:3];
    else if (k >= 6'h1e)
      lane_of = 2'h3;
    else if (k >= 6'h14)
      lane_of = 2'h2;
    else if (k >= 6'h0a)
      lane_of = 2'h1;
    else
      lane_of = 2'h0;
  endfunction : lane_of

endpackage : bram_pkg

// >>> verilog/configurable_block_ram.sv
// Configurable block RAM with two user ports and a Wishbone config slave
`timescale 1ns/10ps
module configurable_block_ram (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       cyc_i,
  input  wire logic                       stb_i,
  input  wire logic                       we_i,
  input  wire logic [7:0]                 adr_i,
  input  wire logic [3:0]                 sel_i,
  input  wire logic [31:0]                dat_i,
  output logic      [31:0]                dat_o,
  output logic                            ack_o,
  input  wire logic                       a_ce_i,
  input  wire logic [bram_pkg::ADDR_W-1:0] a_addr_i,
  input  wire logic [bram_pkg::DATA_W-1:0] a_wdata_i,
  input  wire logic                       a_we_i,
  input  wire logic                       a_re_i,
  input  wire logic [bram_pkg::BE_W-1:0]   a_be_i,
  input  wire logic                       a_aclr_i,
  output logic      [bram_pkg::DATA_W-1:0] a_q_o,
  input  wire logic                       b_ce_i,
  input  wire logic [bram_pkg::ADDR_W-1:0] b_addr_i,
  input  wire logic [bram_pkg::DATA_W-1:0] b_wdata_i,
  input  wire logic                       b_we_i,
  input  wire logic                       b_re_i,
  input  wire logic [bram_pkg::BE_W-1:0]   b_be_i,
  input  wire logic                       b_aclr_i,
  output logic      [bram_pkg::DATA_W-1:0] b_q_o
);
  import bram_pkg::*;

  mem_mode_type      mem_mode;
  clk_mode_type      clk_mode;
  logic              small_sel;
  logic              rdw_new;
  logic [3:0]        code [2];
  logic              cfg_ok;
  logic              col_seen;

  logic [ADDR_W-1:0] addr_in  [2];
  logic [DATA_W-1:0] wd_in    [2];
  logic [BE_W-1:0]   be_in    [2];
  logic              we_in    [2];
  logic              re_in    [2];
  logic              aclr_in  [2];
  logic              in_ce    [2];
  logic              out_ce   [2];
  logic              wr_ok    [2];
  logic              rd_ok    [2];

  logic [ADDR_W-1:0] addr_r   [2];
  logic [DATA_W-1:0] wd_r     [2];
  logic [BE_W-1:0]   be_r     [2];
  logic              we_r     [2];
  logic              re_r     [2];
  logic              fire     [2];
  logic              clr_s1   [2];
  logic              clr_s2   [2];
  logic              cleared  [2];
  logic [DATA_W-1:0] q        [2];

  logic [ADDR_W-1:0] eff_addr [2];
  logic [2:0]        lg       [2];
  logic [5:0]        wid      [2];
  logic              par      [2];
  logic [4:0]        slot     [2];
  logic [5:0]        off      [2];
  logic [ROW_W-1:0]  row      [2];
  logic              wr       [2];
  logic              rd       [2];
  logic              col      [2];
  logic [DATA_W-1:0] wmask    [2];
  logic [DATA_W-1:0] wbits    [2];
  logic [DATA_W-1:0] rrow     [2];
  logic [DATA_W-1:0] rdata    [2];
  logic [DATA_W-1:0] a_new;
  logic [DATA_W-1:0] b_new;
  logic [DATA_W-1:0] a_base;
  logic              same_row;
  logic              rdw_known;

  logic [DATA_W-1:0] mem [ROWS];

  assign addr_in[0] = a_addr_i;
  assign addr_in[1] = b_addr_i;
  assign wd_in[0]   = a_wdata_i;
  assign wd_in[1]   = b_wdata_i;
  assign be_in[0]   = a_be_i;
  assign be_in[1]   = b_be_i;
  assign we_in[0]   = a_we_i;
  assign we_in[1]   = b_we_i;
  assign re_in[0]   = a_re_i;
  assign re_in[1]   = b_re_i;
  assign aclr_in[0] = a_aclr_i;
  assign aclr_in[1] = b_aclr_i;
  assign a_q_o      = q[0];
  assign b_q_o      = q[1];

  // Which enable qualifies which register group in each clocking mode
  always_comb
  begin
    in_ce[0]  = a_ce_i;
    out_ce[0] = (clk_mode == CLK_IO) ? b_ce_i : a_ce_i;
    in_ce[1]  = (clk_mode == CLK_SINGLE || clk_mode == CLK_IO) ? a_ce_i
                                                               : b_ce_i;
    out_ce[1] = (clk_mode == CLK_SINGLE) ? a_ce_i : b_ce_i;
  end

  // Legal pairings of memory mode, clocking mode, block and port shapes
  always_comb
  begin
    cfg_ok = 1'b0;
    case (mem_mode)
      MODE_SP:
        cfg_ok = (clk_mode == CLK_SINGLE || clk_mode == CLK_IO) &&
                 (!small_sel || small_ok(code[0]));
      MODE_SDP:
        cfg_ok = (clk_mode != CLK_INDEP) &&
                 (is_par(code[0]) == is_par(code[1])) &&
                 (!small_sel || (code[0] == code[1] &&
                                 small_ok(code[0])));
      MODE_TDP:
        cfg_ok = (clk_mode != CLK_RW) && !small_sel &&
                 (is_par(code[0]) == is_par(code[1])) &&
                 (width_of(code[0]) <= TDP_MAX_W) &&
                 (width_of(code[1]) <= TDP_MAX_W);
      MODE_ROM:
        cfg_ok = (clk_mode != CLK_RW) &&
                 (is_par(code[0]) == is_par(code[1])) &&
                 (!small_sel || (clk_mode != CLK_INDEP &&
                                 small_ok(code[0])));
      default:
        cfg_ok = 1'b0;
    endcase
    if (code[0] > W40 || code[1] > W40)
      cfg_ok = 1'b0;
    wr_ok[0] = cfg_ok && (mem_mode != MODE_ROM);
    wr_ok[1] = cfg_ok && (mem_mode == MODE_TDP);
    rd_ok[0] = cfg_ok && (mem_mode != MODE_SDP);
    rd_ok[1] = cfg_ok && (mem_mode != MODE_SP);
  end

  genvar p;
  genvar b;
  genvar k;
  generate
    for (p = 0; p < 2; p++)
    begin : g_port
      // Small block write side has no enable on address, data, byte enable
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          addr_r[p] <= '0;
          wd_r[p]   <= '0;
        end
        else if (in_ce[p] || (small_sel && p == 0))
        begin
          addr_r[p] <= addr_in[p];
          wd_r[p]   <= wd_in[p];
        end
      end

      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          we_r[p] <= 1'b0;
          re_r[p] <= 1'b0;
          fire[p] <= 1'b0;
        end
        else
        begin
          fire[p] <= in_ce[p];
          if (in_ce[p])
          begin
            we_r[p] <= we_in[p];
            re_r[p] <= re_in[p];
          end
        end
      end

      // Byte enables: all ones after reset, untouched by the output clear
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          be_r[p] <= '1;
        else if (in_ce[p] || (small_sel && p == 0))
          be_r[p] <= be_in[p];
      end

      // Clear pin is asynchronous to the fabric clock
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          clr_s1[p] <= 1'b0;
          clr_s2[p] <= 1'b0;
        end
        else
        begin
          clr_s1[p] <= aclr_in[p];
          clr_s2[p] <= clr_s1[p];
        end
      end

      // Only the output register is cleared; it holds zero until a read
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          q[p]       <= '0;
          cleared[p] <= 1'b0;
        end
        else if (clr_s2[p])
        begin
          q[p]       <= '0;
          cleared[p] <= 1'b1;
        end
        else if (rd[p] && out_ce[p])
        begin
          q[p]       <= col[p] ? '0 : rdata[p];
          cleared[p] <= 1'b0;
        end
      end

      assign eff_addr[p] = small_sel ? (addr_r[p] & small_mask(code[p]))
                                     : addr_r[p];
      assign lg[p]   = lg_items(code[p]);
      assign wid[p]  = width_of(code[p]);
      assign par[p]  = is_par(code[p]);
      assign row[p]  = ROW_W'(eff_addr[p] >> lg[p]);
      assign slot[p] = 5'(eff_addr[p] & ADDR_W'((14'h0001 << lg[p]) -
                                                14'h0001));
      assign off[p]  = 6'(slot[p] * wid[p]);
      assign wr[p]   = fire[p] && we_r[p] && wr_ok[p];
      assign rd[p]   = fire[p] && re_r[p] && rd_ok[p];

      // Physical bit b of a row against the port's logical word
      for (b = 0; b < DATA_W; b++)
      begin : g_wbit
        localparam logic [5:0] BP  = 6'(b);
        localparam logic [5:0] VNP = 6'((b / 5) * 4 + (b % 5));
        localparam bit         PP  = ((b % 5) == 4);
        logic [5:0] v;
        logic       hit;
        logic [5:0] kk;
        logic [1:0] ln;
        assign v   = par[p] ? BP : VNP;
        assign hit = (par[p] || !PP) && (v >= off[p]) &&
                     (v < 6'(off[p] + wid[p]));
        assign kk  = hit ? 6'(v - off[p]) : 6'h00;
        assign ln  = lane_of(kk, par[p]);
        assign wmask[p][b] = hit && wr[p] && be_r[p][ln];
        assign wbits[p][b] = wd_r[p][kk];
      end

      // Logical read bit k taken from its physical position
      for (k = 0; k < DATA_W; k++)
      begin : g_rbit
        localparam logic [5:0] KK = 6'(k);
        logic [6:0] lin;
        logic [5:0] ph;
        assign lin = 7'(off[p]) + 7'(KK);
        assign ph  = (KK >= wid[p]) ? 6'h00 :
                     par[p] ? lin[5:0] :
                     ({1'b0, lin[6:2]} * 6'h05) + {4'h0, lin[1:0]};
        assign rdata[p][k] = (KK < wid[p]) ? rrow[p][ph] : 1'b0;
      end
    end
  endgenerate

  assign same_row  = (row[0] == row[1]);
  assign rdw_known = (clk_mode == CLK_SINGLE) || (clk_mode == CLK_IO);

  // Merge both ports' writes; port A lands last on a shared row
  always_comb
  begin
    b_new  = (mem[row[1]] & ~wmask[1]) | (wbits[1] & wmask[1]);
    a_base = (wr[1] && same_row) ? b_new : mem[row[0]];
    a_new  = (a_base & ~wmask[0]) | (wbits[0] & wmask[0]);
    rrow[0] = mem[row[0]];
    rrow[1] = mem[row[1]];
    if (rdw_new && rdw_known && (wr[0] || (wr[1] && same_row)))
      rrow[0] = wr[0] ? a_new : b_new;
    if (rdw_new && rdw_known && (wr[1] || (wr[0] && same_row)))
      rrow[1] = (wr[0] && same_row) ? a_new : b_new;
    col[0] = (clk_mode == CLK_RW) && wr[1] && rd[0] && same_row;
    col[1] = (clk_mode == CLK_RW) && wr[0] && rd[1] && same_row;
  end

  always_ff @(posedge clk_i)
  begin
    if (wr[1])
      mem[row[1]] <= b_new;
    if (wr[0])
      mem[row[0]] <= a_new;
  end

  // Wishbone classic slave, one wait state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= cyc_i && stb_i && !ack_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mem_mode  <= mem_mode_type'(MODE_RST);
      clk_mode  <= clk_mode_type'(CLK_RST);
      small_sel <= 1'b0;
      rdw_new   <= 1'b0;
      code[0]   <= SHAPE_RST;
      code[1]   <= SHAPE_RST;
    end
    else if (cyc_i && stb_i && ack_o && we_i)
    begin
      case (adr_i)
        CTRL_OFS:
          if (sel_i[0])
          begin
            mem_mode  <= mem_mode_type'(dat_i[CTRL_MODE_LSB +: 2]);
            clk_mode  <= clk_mode_type'(dat_i[CTRL_CLK_LSB +: 2]);
            small_sel <= dat_i[CTRL_SMALL_BIT];
            rdw_new   <= dat_i[CTRL_RDW_BIT];
          end
        SHAPE_OFS:
        begin
          if (sel_i[0])
            code[0] <= dat_i[SHAPE_A_LSB +: 4];
          if (sel_i[1])
            code[1] <= dat_i[SHAPE_B_LSB +: 4];
        end
        default:
          ;
      endcase
    end
  end

  // Sticky collision flag; a new collision wins over a write-one clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      col_seen <= 1'b0;
    else if ((col[0] && rd[0]) || (col[1] && rd[1]))
      col_seen <= 1'b1;
    else if (cyc_i && stb_i && ack_o && we_i && adr_i == STATUS_OFS &&
             sel_i[0] && dat_i[STATUS_COL_BIT])
      col_seen <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= '0;
    else if (cyc_i && stb_i && !ack_o)
    begin
      dat_o <= '0;
      case (adr_i)
        CTRL_OFS:
        begin
          dat_o[CTRL_MODE_LSB +: 2] <= mem_mode;
          dat_o[CTRL_CLK_LSB +: 2]  <= clk_mode;
          dat_o[CTRL_SMALL_BIT]     <= small_sel;
          dat_o[CTRL_RDW_BIT]       <= rdw_new;
        end
        SHAPE_OFS:
        begin
          dat_o[SHAPE_A_LSB +: 4] <= code[0];
          dat_o[SHAPE_B_LSB +: 4] <= code[1];
        end
        STATUS_OFS:
        begin
          dat_o[STATUS_OK_BIT]   <= cfg_ok;
          dat_o[STATUS_CLRA_BIT] <= cleared[0];
          dat_o[STATUS_CLRB_BIT] <= cleared[1];
          dat_o[STATUS_COL_BIT]  <= col_seen;
        end
        default:
          dat_o <= '0;
      endcase
    end
  end

endmodule : configurable_block_ram

// >>> dv/fabric_port_model.sv
// Fabric-side user logic driving one port of the block RAM
`timescale 1ns/10ps
module fabric_port_model (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        req_i,
  input  wire logic                        we_i,
  input  wire logic                        re_i,
  input  wire logic [bram_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [bram_pkg::DATA_W-1:0] wdata_i,
  input  wire logic [bram_pkg::BE_W-1:0]   be_i,
  output logic                             ce_o,
  output logic                             we_o,
  output logic                             re_o,
  output logic      [bram_pkg::ADDR_W-1:0] addr_o,
  output logic      [bram_pkg::DATA_W-1:0] wdata_o,
  output logic      [bram_pkg::BE_W-1:0]   be_o
);
  import bram_pkg::*;
  logic held;

  // Enable stays up one more edge for the output stage; fields stay put
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      held <= 1'b0;
      ce_o <= 1'b0;
      we_o <= 1'b0;
      re_o <= 1'b0;
      addr_o <= '0;
      wdata_o <= '0;
      be_o <= '1;
    end
    else
    begin
      held <= req_i;
      ce_o <= req_i | held;
      we_o <= req_i & we_i;
      re_o <= req_i & re_i;
      if (req_i)
      begin
        addr_o <= addr_i;
        wdata_o <= wdata_i;
        be_o <= be_i;
      end
      else if (!held)
      begin
        // Released lines invert every cycle instead of holding their last value
        addr_o <= ~addr_o;
        wdata_o <= ~wdata_o;
        be_o <= ~be_o;
      end
    end
  end
endmodule : fabric_port_model

// >>> dv/configurable_block_ram_assertions.sv
// Port-level checker for the configurable block RAM
`timescale 1ns/10ps
module block_ram_checker (
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  input wire logic                        cyc_i,
  input wire logic                        stb_i,
  input wire logic                        we_i,
  input wire logic [7:0]                  adr_i,
  input wire logic [31:0]                 dat_o,
  input wire logic                        ack_o,
  input wire logic                        a_re_i,
  input wire logic                        a_aclr_i,
  input wire logic [bram_pkg::DATA_W-1:0] a_q_o,
  input wire logic                        b_re_i,
  input wire logic                        b_aclr_i,
  input wire logic [bram_pkg::DATA_W-1:0] b_q_o
);
  import bram_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence wb_req_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence a_idle_s;
    !a_re_i ##1 a_q_o == '0;
  endsequence
  sequence b_idle_s;
    !b_re_i ##1 b_q_o == '0;
  endsequence

  ack_follows_a: assert property (wb_req_s |=> ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  unmapped_zero_a: assert property (
    wb_req_s ##0 (!we_i && adr_i == 8'h0c) |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_clear_a: assert property ($rose(a_aclr_i) |-> ##[1:4] a_q_o == '0)
    else $error("port a output not cleared");
  b_clear_a: assert property ($rose(b_aclr_i) |-> ##[1:4] b_q_o == '0)
    else $error("port b output not cleared");
  a_hold_clear_a: assert property (a_idle_s |=> a_q_o == '0)
    else $error("port a output left zero without read");
  b_hold_clear_a: assert property (b_idle_s |=> b_q_o == '0)
    else $error("port b output left zero without read");
endmodule : block_ram_checker

bind configurable_block_ram block_ram_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .a_re_i(a_re_i), .a_aclr_i(a_aclr_i), .a_q_o(a_q_o),
  .b_re_i(b_re_i), .b_aclr_i(b_aclr_i), .b_q_o(b_q_o)
);

// >>> dv/configurable_block_ram_bench.sv
// Self-checking bench for the configurable block RAM
`timescale 1ns/10ps
module configurable_block_ram_bench;
  import bram_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o;
  logic [1:0]  req, pwe, pre, aclr, ce, we, re, ra, rb;
  logic [13:0] addr [2];
  logic [13:0] pa [2];
  logic [39:0] wd [2];
  logic [39:0] pd [2];
  logic [39:0] q [2];
  logic [3:0]  be [2];
  logic [3:0]  pb [2];
  logic [39:0] pq [2][$];
  logic [63:0] wq [$];
  logic [63:0] wv;
  logic [39:0] d, e;
  int          num_errors, total_checks;
  logic [20:0] cfgt [14] = '{
    {8'h01, 12'h804, 1'b1}, {8'h01, 12'h403, 1'b0},
    {8'h02, 12'h707, 1'b1}, {8'h02, 12'h909, 1'b0},
    {8'h02, 12'h305, 1'b1}, {8'h02, 12'h306, 1'b0},
    {8'h04, 12'h909, 1'b0}, {8'h05, 12'h909, 1'b1},
    {8'h0f, 12'h909, 1'b1}, {8'h0c, 12'h909, 1'b0},
    {8'h09, 12'h909, 1'b1}, {8'h10, 12'h707, 1'b1},
    {8'h10, 12'h808, 1'b0}, {8'h11, 12'h604, 1'b0}};
  logic [3:0]  bev [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'ha};

  configurable_block_ram u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o),
    .a_ce_i(ce[0]), .a_addr_i(pa[0]), .a_wdata_i(pd[0]),
    .a_we_i(we[0]), .a_re_i(re[0]), .a_be_i(pb[0]),
    .a_aclr_i(aclr[0]), .a_q_o(q[0]),
    .b_ce_i(ce[1]), .b_addr_i(pa[1]), .b_wdata_i(pd[1]),
    .b_we_i(we[1]), .b_re_i(re[1]), .b_be_i(pb[1]),
    .b_aclr_i(aclr[1]), .b_q_o(q[1]));

  fabric_port_model u_pa (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req[0]), .we_i(pwe[0]),
    .re_i(pre[0]), .addr_i(addr[0]), .wdata_i(wd[0]), .be_i(be[0]),
    .ce_o(ce[0]), .we_o(we[0]), .re_o(re[0]), .addr_o(pa[0]),
    .wdata_o(pd[0]), .be_o(pb[0]));
  fabric_port_model u_pb (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req[1]), .we_i(pwe[1]),
    .re_i(pre[1]), .addr_i(addr[1]), .wdata_i(wd[1]), .be_i(be[1]),
    .ce_o(ce[1]), .we_o(we[1]), .re_o(re[1]), .addr_o(pa[1]),
    .wdata_o(pd[1]), .be_o(pb[1]));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic check_word(input string n, input logic [39:0] x, g);
    total_checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask : check_word

  task automatic check_reg(input logic [31:0] x, g, m);
    total_checks++;
    if ((g & m) !== x)
    begin
      num_errors++;
      $display("Error dat_o expected %h seen %h", x, g & m);
    end
  endtask : check_reg

  task automatic complete_run();
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  function automatic logic [39:0] rnd40();
    rnd40 = {8'($urandom), 32'($urandom)};
  endfunction : rnd40

  // Lanes are ten bits wide with parity, eight bits wide without
  function automatic logic [39:0] merge(input logic [39:0] o, n,
                                        input logic [3:0] b, input bit p);
    merge = o;
    for (int k = 0; k < (p ? 40 : 32); k++)
      if (b[p ? k / 10 : k / 8])
        merge[k] = n[k];
  endfunction : merge

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] x, m);
    if (!w)
      wq.push_back({m, x});
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= w ? x : 32'($urandom);
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  task automatic cfg(input logic [7:0] c, input logic [11:0] s);
    wb(1'b1, CTRL_OFS, {24'h0, c}, '1);
    wb(1'b1, SHAPE_OFS, {20'h0, s}, '1);
  endtask : cfg

  task automatic op(input logic [1:0] wm, rm, input logic [13:0] a,
                    input logic [39:0] x, r, input logic [3:0] b);
    for (int p = 0; p < 2; p++)
      if (rm[p])
        pq[p].push_back(r);
    @(posedge clk_i);
    req <= wm | rm;
    pwe <= wm;
    pre <= rm;
    addr <= '{a, a};
    wd <= '{x, x};
    be <= '{b, b};
    @(posedge clk_i);
    req <= 2'b00;
    repeat (4) @(posedge clk_i);
  endtask : op

  task automatic clr(input int p);
    @(posedge clk_i);
    aclr[p] <= 1'b1;
    @(posedge clk_i);
    aclr[p] <= 1'b0;
    repeat (5) @(posedge clk_i);
    check_word("q_cleared", 40'h0, q[p]);
  endtask : clr

  // Results are matched in arrival order against the noted expectations
  always @(posedge clk_i)
  begin
    ra <= {ra[0], ce[0] & re[0]};
    rb <= {rb[0], ce[1] & re[1]};
    if (ra[1] === 1'b1)
      check_word("a_q_o", pq[0].pop_front(), q[0]);
    if (rb[1] === 1'b1)
      check_word("b_q_o", pq[1].pop_front(), q[1]);
    if (ack_o === 1'b1 && we_i === 1'b0)
    begin
      wv = wq.pop_front();
      check_reg(wv[31:0], dat_o, wv[63:32]);
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    complete_run();
  end

  initial
  begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    rst_i = 1'b1;
    {req, pwe, pre, aclr, ra, rb} = '0;
    addr = '{14'h0, 14'h0};
    wd = '{40'h0, 40'h0};
    be = '{4'hf, 4'hf};
    num_errors = 0;
    total_checks = 0;
    void'($urandom(32'h5c72));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CTRL_OFS, 32'h0, '1);
    wb(1'b0, SHAPE_OFS, 32'h909, '1);
    wb(1'b0, STATUS_OFS, 32'h1, 32'h1);
    wb(1'b1, 8'h0c, 32'($urandom), '1);
    wb(1'b0, 8'h0c, 32'h0, '1);
    for (int i = 0; i < 14; i++)
    begin
      cfg(cfgt[i][20:13], cfgt[i][12:1]);
      wb(1'b0, STATUS_OFS, {31'h0, cfgt[i][0]}, 32'h1);
    end
    cfg(8'h00, 12'h909);
    e = rnd40();
    op(2'b01, 2'b00, 14'h5, e, 40'h0, 4'hf);
    op(2'b01, 2'b00, 14'h1ff, rnd40(), 40'h0, 4'hf);
    op(2'b00, 2'b01, 14'h5, 40'h0, e, 4'hf);
    for (int i = 0; i < 6; i++)
    begin
      d = rnd40();
      e = merge(e, d, bev[i], 1'b1);
      op(2'b01, 2'b00, 14'h5, d, 40'h0, bev[i]);
      op(2'b00, 2'b01, 14'h5, 40'h0, e, 4'hf);
    end
    clr(0);
    wb(1'b0, STATUS_OFS, 32'h3, 32'h3);
    cfg(8'h20, 12'h909);
    e = rnd40();
    op(2'b01, 2'b01, 14'h9, e, e, 4'hf);
    cfg(8'h00, 12'h909);
    op(2'b01, 2'b01, 14'h9, rnd40(), e, 4'hf);
    cfg(8'h00, 12'h606);
    d = rnd40();
    e = {24'h0, d[15:0]};
    op(2'b01, 2'b00, 14'h3ff, d, 40'h0, 4'hf);
    op(2'b00, 2'b01, 14'h3ff, 40'h0, e, 4'hf);
    d = rnd40();
    e = merge(e, d, 4'h1, 1'b0) & 40'hffff;
    op(2'b01, 2'b00, 14'h3ff, d, 40'h0, 4'h1);
    op(2'b00, 2'b01, 14'h3ff, 40'h0, e, 4'hf);
    cfg(8'h05, 12'h804);
    d = rnd40();
    for (int i = 0; i < 4; i++)
      op(2'b01, 2'b00, 14'(8 + i), d >> (8 * i), 40'h0, 4'hf);
    op(2'b00, 2'b10, 14'h2, 40'h0, {8'h0, d[31:0]}, 4'hf);
    clr(1);
    op(2'b00, 2'b10, 14'h2, 40'h0, {8'h0, d[31:0]}, 4'hf);
    cfg(8'h0e, 12'h507);
    d = rnd40();
    op(2'b01, 2'b00, 14'h3, d, 40'h0, 4'hf);
    op(2'b00, 2'b10, 14'h7, 40'h0, {30'h0, d[19:10]}, 4'hf);
    cfg(8'h10, 12'h707);
    d = rnd40();
    op(2'b01, 2'b00, 14'h25, d, 40'h0, 4'hf);
    op(2'b00, 2'b01, 14'h5, 40'h0, {20'h0, d[19:0]}, 4'hf);
    cfg(8'h05, 12'h909);
    op(2'b01, 2'b10, 14'h7, rnd40(), 40'h0, 4'hf);
    wb(1'b0, STATUS_OFS, 32'h8, 32'h8);
    wb(1'b1, STATUS_OFS, 32'h8, '1);
    wb(1'b0, STATUS_OFS, 32'h0, 32'h8);
    complete_run();
  end
endmodule : configurable_block_ram_bench
